/* File: src/flash_regs_defs.vh */
/*
 * Constants for the flash clock, security and index register slice.
 * Assumes inclusion by bare name from the register slice module only.
 */
`ifndef FLASH_REGS_DEFS_VH
`define FLASH_REGS_DEFS_VH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------
`define IDX_TIMING_DIVIDER 2'h0
`define IDX_SECURITY       2'h1
`define IDX_COMMAND_INDEX  2'h2
`define IDX_ECC_INDEX      2'h3
`define IDX_STATUS         3'h4

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define DIV_LOADED_BIT     7
`define DIV_VALUE_MSB      6
`define INDEX_MSB          2
`define KEY_MSB            7
`define KEY_LSB            6
`define SEC_MSB            1
`define SEC_LSB            0
`define SEC_UNSECURED      2'h2
`define SEC_ALL_SET        8'hff
`define DIV_RESET          7'h00
`define INDEX_RESET        3'h0
`define KEY_ENABLED        2'h2
`define SYNC_STAGES        2

// ----------------------------------------------------------------------
// Security byte location in the nonvolatile configuration field.
// ----------------------------------------------------------------------
`define SECURITY_BYTE_ADDR 23'h7f_ff0f

`endif

/* File: src/flash_clock_security_index_regs.v */
/*
 * Register slice of an embedded flash controller: timing divider, security
 * shadow, command word index and ecc result index, on an Avalon-MM slave.
 * Assumes the reset sequencer supplies the security byte and its fault flag
 * on the same clock, and the oscillator clock comes in as an asynchronous pin.
 */
// How it works
// - Divider writes accepted during flash reset sequence.
// - Divided timing clock lands near one megahertz.
// - Security register readable, writes ignored.
// - Security loaded from nonvolatile byte at reset.
// - Double-bit fault at load sets all security bits.
// - Backdoor enabled only when key field is 10.
// - Unsecured only when security field is 10.
// - Backdoor unlock forces security field to 10.
// - Command index selects command object array word.
// - Command index: only index field writable, rest zero.
// - Ecc index selects ecc result array word.
// - Ecc index: only index field writable, rest zero.
// - Divider bits 6-0 write once, bit 7 read-only.
// - Bit 7 shows divider written since reset.
// - Divider divides oscillator clock into timing clock.
`timescale 1ns/100ps
`include "flash_regs_defs.vh"

module flash_clock_security_index_regs (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rstn,
   // Avalon-MM slave
   input  wire [4:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   input  wire [3:0]  byteenable,
   output reg  [31:0] readdata,
   output reg         waitrequest,
   output reg  [1:0]  response,
   // Reset sequencer
   input  wire        reset_sequence_active,
   input  wire        security_load,
   input  wire [7:0]  security_byte,
   input  wire        security_double_fault,
   input  wire        backdoor_unlock,
   // Flash core side
   input  wire        oscillator_clock,
   output reg         flash_timing_clock,
   output reg  [2:0]  command_index_field,
   output reg  [2:0]  ecc_index_field,
   output reg         backdoor_access_enabled,
   output reg         flash_unsecured
);

   // ----------------------------------------------------------------------
   // Decoding used by several processes.
   // ----------------------------------------------------------------------
   function [1:0] index_of;
      input [4:0] addr;
      begin
         index_of = addr[3:2];
      end
   endfunction

   function in_map;
      input [4:0] addr;
      begin
         in_map = (addr[1:0] == 2'h0) && (addr[4:2] <= `IDX_STATUS);
      end
   endfunction

   function hits;
      input [4:0] addr;
      input [1:0] target;
      begin
         hits = in_map(addr) && !addr[4] && (index_of(addr) == target);
      end
   endfunction

   // Only one code of a two-bit field opens; the three others stay closed.
   function field_open;
      input [1:0] field;
      input [1:0] open_code;
      begin
         field_open = (field == open_code);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Registers and wires.
   // ----------------------------------------------------------------------
   localparam BUS_IDLE   = 1'b0;
   localparam BUS_ANSWER = 1'b1;

   reg                     bus_state;
   reg                     next_bus_state;
   reg  [6:0]              divide_value;
   reg                     divider_loaded_flag;
   reg  [7:0]              security_shadow;
   reg  [`SYNC_STAGES-1:0] osc_sync;
   reg                     osc_prev;
   reg  [6:0]              edge_count;
   reg  [31:0]             next_readdata;

   wire                    request;
   wire                    take;
   wire                    write_take;
   wire                    lane_ok;
   wire                    wr_divider;
   wire                    wr_command_index;
   wire                    wr_ecc_index;
   wire                    rd_hit;
   wire [7:0]              rd_divider;
   wire [7:0]              rd_security;
   wire [7:0]              rd_command_index;
   wire [7:0]              rd_ecc_index;
   wire [31:0]             rd_status;
   wire [1:0]              key_field;
   wire [1:0]              sec_field;
   wire [`SYNC_STAGES-1:0] osc_chain;
   wire                    osc_rise;
   wire                    count_done;

   // ----------------------------------------------------------------------
   // Bus handshake: one wait cycle, then answer; no error for any write.
   // ----------------------------------------------------------------------
   assign request = read || write;
   assign take    = request && (bus_state == BUS_IDLE);

   always @* begin
      next_bus_state = BUS_IDLE;
      case (bus_state)
         BUS_IDLE: begin
            if (request) begin
               next_bus_state = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            // The master drops its request at this edge, so a request never chains.
            next_bus_state = BUS_IDLE;
         end
         default: begin
            next_bus_state = BUS_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (!rstn) begin
         bus_state   <= BUS_IDLE;
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
         response    <= 2'h0;
      end else begin
         bus_state   <= next_bus_state;
         waitrequest <= !take;
         readdata    <= next_readdata;
         response    <= 2'h0;
      end
   end

   // ----------------------------------------------------------------------
   // Write strobes; only byte lane 0 carries register data.
   // ----------------------------------------------------------------------
   assign write_take       = take && write;
   assign lane_ok          = byteenable[0];
   assign wr_divider       = write_take && lane_ok
                             && hits(address, `IDX_TIMING_DIVIDER);
   assign wr_command_index = write_take && lane_ok
                             && hits(address, `IDX_COMMAND_INDEX);
   assign wr_ecc_index     = write_take && lane_ok
                             && hits(address, `IDX_ECC_INDEX);

   // ----------------------------------------------------------------------
   // Read path; unused bits and unmapped words read zero.
   // ----------------------------------------------------------------------
   assign rd_hit           = take && read && in_map(address);
   assign rd_divider       = {divider_loaded_flag, divide_value};
   assign rd_security      = security_shadow;
   assign rd_command_index = {5'h00, command_index_field};
   assign rd_ecc_index     = {5'h00, ecc_index_field};
   assign rd_status        = {31'h0000_0000, reset_sequence_active};

   always @* begin
      next_readdata = 32'h0000_0000;
      if (rd_hit) begin
         if (address[4]) begin
            next_readdata = rd_status;
         end else begin
            case (index_of(address))
               `IDX_TIMING_DIVIDER: begin
                  next_readdata = {24'h00_0000, rd_divider};
               end
               `IDX_SECURITY: begin
                  next_readdata = {24'h00_0000, rd_security};
               end
               `IDX_COMMAND_INDEX: begin
                  next_readdata = {24'h00_0000, rd_command_index};
               end
               `IDX_ECC_INDEX: begin
                  next_readdata = {24'h00_0000, rd_ecc_index};
               end
               default: begin
                  next_readdata = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Divider: write once after reset, even during the reset sequence.
   // ----------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!rstn) begin
         divide_value <= `DIV_RESET;
      end else if (wr_divider && !divider_loaded_flag) begin
         // The reset sequence does not block this write, as the core is idle then.
         divide_value <= writedata[`DIV_VALUE_MSB:0];
      end
   end

   always @(posedge sys_clk) begin
      if (!rstn) begin
         divider_loaded_flag <= 1'b0;
      end else if (wr_divider) begin
         divider_loaded_flag <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Security shadow: load at reset, force all ones on a double fault.
   // ----------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!rstn) begin
         security_shadow <= `SEC_ALL_SET;
      end else if (security_load) begin
         // A load outranks an unlock in the same cycle, keeping the safer value.
         if (security_double_fault) begin
            security_shadow <= `SEC_ALL_SET;
         end else begin
            security_shadow <= security_byte;
         end
      end else if (backdoor_unlock) begin
         security_shadow[`SEC_MSB:`SEC_LSB] <= `SEC_UNSECURED;
      end
   end

   assign key_field = security_shadow[`KEY_MSB:`KEY_LSB];
   assign sec_field = security_shadow[`SEC_MSB:`SEC_LSB];

   always @(posedge sys_clk) begin
      if (!rstn) begin
         backdoor_access_enabled <= 1'b0;
      end else begin
         backdoor_access_enabled <= field_open(key_field, `KEY_ENABLED);
      end
   end

   always @(posedge sys_clk) begin
      if (!rstn) begin
         flash_unsecured <= 1'b0;
      end else begin
         flash_unsecured <= field_open(sec_field, `SEC_UNSECURED);
      end
   end

   // ----------------------------------------------------------------------
   // Index registers; only the low three bits are stored.
   // ----------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!rstn) begin
         command_index_field <= `INDEX_RESET;
      end else if (wr_command_index) begin
         command_index_field <= writedata[`INDEX_MSB:0];
      end
   end

   always @(posedge sys_clk) begin
      if (!rstn) begin
         ecc_index_field <= `INDEX_RESET;
      end else if (wr_ecc_index) begin
         ecc_index_field <= writedata[`INDEX_MSB:0];
      end
   end

   // ----------------------------------------------------------------------
   // Timing clock: toggle every divide_value+1 oscillator rising edges.
   // ----------------------------------------------------------------------
   // The pin is sampled by the system clock, so it must be well slower.
   assign osc_chain = {osc_sync[`SYNC_STAGES-2:0], oscillator_clock};

   genvar stage;
   generate
      for (stage = 0; stage < `SYNC_STAGES; stage = stage + 1) begin : g_sync
         always @(posedge sys_clk) begin
            if (!rstn) begin
               osc_sync[stage] <= 1'b0;
            end else begin
               osc_sync[stage] <= osc_chain[stage];
            end
         end
      end
   endgenerate

   assign osc_rise   = osc_sync[`SYNC_STAGES-1] && !osc_prev;
   assign count_done = (edge_count >= divide_value);

   always @(posedge sys_clk) begin
      if (!rstn) begin
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= osc_sync[`SYNC_STAGES-1];
      end
   end

   always @(posedge sys_clk) begin
      if (!rstn) begin
         edge_count <= 7'h00;
      end else if (divider_loaded_flag && osc_rise) begin
         if (count_done) begin
            edge_count <= 7'h00;
         end else begin
            edge_count <= edge_count + 7'h01;
         end
      end
   end

   always @(posedge sys_clk) begin
      if (!rstn) begin
         flash_timing_clock <= 1'b0;
      end else if (divider_loaded_flag && osc_rise && count_done) begin
         flash_timing_clock <= !flash_timing_clock;
      end
   end

endmodule

/* File: tb/flash_regs_properties.sv */
/* Checker for the flash register slice: bus answers and security outputs.
   Assumes it is bound to the top module; one clock, sync active-low reset. */
`timescale 1ns/100ps
module flash_regs_checker (
   // Watched ports
   input wire        sys_clk,
   input wire        rstn,
   input wire [4:0]  address,
   input wire        read,
   input wire        write,
   input wire [31:0] readdata,
   input wire        waitrequest,
   input wire [1:0]  response,
   input wire        security_load,
   input wire [7:0]  security_byte,
   input wire        security_double_fault,
   input wire        backdoor_unlock,
   input wire [2:0]  command_index_field,
   input wire [2:0]  ecc_index_field,
   input wire        backdoor_access_enabled,
   input wire        flash_unsecured
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire done = read && !waitrequest;
   AST_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("Request not answered after one wait");
   AST_ONE_CYCLE: assert property (!waitrequest |=> waitrequest)
      else $error("Answer stood longer than one cycle");
   AST_NO_ERROR: assert property (!waitrequest |-> response == 2'b00)
      else $error("Error response seen");
   AST_CMD_IDX: assert property (done && address == 5'h08 |-> readdata == {29'h0, command_index_field})
      else $error("Command index read mismatch");
   AST_ECC_IDX: assert property (done && address == 5'h0c |-> readdata == {29'h0, ecc_index_field})
      else $error("Ecc index read mismatch");
   AST_FAULT_LOAD: assert property (security_load && security_double_fault ##1 !security_load && !backdoor_unlock |=> !backdoor_access_enabled && !flash_unsecured)
      else $error("Faulted load left part open");
   AST_KEY: assert property (security_load && !security_double_fault ##1 !security_load && !backdoor_unlock |=> backdoor_access_enabled == ($past(security_byte, 2) >> 6 == 8'h02))
      else $error("Backdoor enable decode wrong");
   AST_SEC: assert property (security_load && !security_double_fault ##1 !security_load && !backdoor_unlock |=> flash_unsecured == ($past(security_byte, 2) % 4 == 2))
      else $error("Security decode wrong");
   AST_UNLOCK: assert property (backdoor_unlock && !security_load ##1 !security_load |=> flash_unsecured)
      else $error("Unlock did not open part");
endmodule

bind flash_clock_security_index_regs flash_regs_checker chk_i (.*);

/* File: tb/test_flash_clock_security_index_regs.sv */
/* Self-checking bench for the flash register slice.
   Assumes the checker is bound from its own file; one clock at 250 MHz. */
`timescale 1ns/100ps
module test_flash_clock_security_index_regs;
   reg         sys_clk, rstn, read, write, reset_sequence_active, oscillator_clock;
   reg         security_load, security_double_fault, backdoor_unlock, ftc_d;
   reg  [4:0]  address;
   reg  [3:0]  byteenable;
   reg  [7:0]  security_byte, b;
   reg  [31:0] writedata, seed, rd;
   reg  [2:0]  oc;
   wire [31:0] readdata;
   wire [1:0]  response;
   wire [2:0]  command_index_field, ecc_index_field;
   wire        waitrequest, flash_timing_clock, backdoor_access_enabled, flash_unsecured;
   integer     err_count, n_checks, i, span, cnt;
   flash_clock_security_index_regs dut (.*);
   initial begin
      sys_clk = 0;
      forever #2 sys_clk = ~sys_clk;
   end
   // The oscillator runs at an eighth of the bus clock, so a toggle span is 8*(div+1).
   always @(posedge sys_clk) begin
      oc <= oc + 3'h1;
      oscillator_clock <= oc[2];
      ftc_d <= flash_timing_clock;
      cnt <= (flash_timing_clock !== ftc_d) ? 1 : cnt + 1;
      if (flash_timing_clock !== ftc_d) span <= cnt;
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function [7:0] sec_exp(input [7:0] v, input f);
      sec_exp = f ? 8'hff : v;
   endfunction
   task report_and_stop;
      begin
         if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   // Holds the request until waitrequest is sampled low, then releases it.
   task bus(input w, input [4:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge sys_clk);
         address <= a;
         write <= w;
         read <= !w;
         writedata <= d;
         n = 0;
         do begin
            @(posedge sys_clk);
            n = n + 1;
         end while (waitrequest !== 1'b0 && n < 50);
         rd = readdata;
         read <= 0;
         write <= 0;
         if (waitrequest !== 1'b0) begin
            err_count = err_count + 1;
            report_and_stop;
         end
      end
   endtask
   task ld(input [7:0] v, input f);
      begin
         @(posedge sys_clk);
         security_byte <= v;
         security_double_fault <= f;
         security_load <= 1;
         @(posedge sys_clk);
         security_load <= 0;
      end
   endtask
   initial begin
      {read, write, security_load, security_double_fault, backdoor_unlock} = 0;
      {rstn, oscillator_clock, ftc_d, oc, address, security_byte} = 0;
      {writedata, cnt, span, err_count, n_checks} = 0;
      reset_sequence_active = 1;
      byteenable = 4'hf;
      seed = 32'h352d_bf22;
      repeat (3) @(posedge sys_clk);
      rstn <= 1;
      bus(0, 5'h04, 0); chk(rd, 32'hff);
      bus(0, 5'h14, 0); chk(rd, 0);
      bus(0, 5'h10, 0); chk(rd, 1);
      seed = lfsr(seed);
      bus(1, 5'h00, {seed[31:7], 7'h2f});
      bus(0, 5'h00, 0); chk(rd, 32'haf);
      seed = lfsr(seed);
      bus(1, 5'h00, seed);
      bus(0, 5'h00, 0); chk(rd, 32'haf);
      byteenable <= 4'he;
      bus(1, 5'h08, 32'h0000_0007);
      byteenable <= 4'hf;
      bus(0, 5'h08, 0); chk(rd, 0);
      for (i = 0; i < 8; i = i + 1) begin
         seed = lfsr(seed);
         bus(1, 5'h08, seed);
         bus(1, 5'h0c, ~seed);
         bus(0, 5'h08, 0); chk(rd, {29'h0, seed[2:0]});
         chk({29'h0, command_index_field}, {29'h0, seed[2:0]});
         bus(0, 5'h0c, 0); chk(rd, {29'h0, ~seed[2:0]});
         chk({29'h0, ecc_index_field}, {29'h0, ~seed[2:0]});
      end
      for (i = 0; i < 17; i = i + 1) begin
         seed = lfsr(seed);
         b = {i[3:2], 4'hf, i[1:0]};
         ld(b, i == 16);
         bus(1, 5'h04, ~seed);
         bus(0, 5'h04, 0); chk(rd, {24'h0, sec_exp(b, i == 16)});
         chk(backdoor_access_enabled, sec_exp(b, i == 16) >> 6 == 2);
         chk(flash_unsecured, sec_exp(b, i == 16) % 4 == 2);
      end
      @(posedge sys_clk);
      backdoor_unlock <= 1;
      @(posedge sys_clk);
      backdoor_unlock <= 0;
      bus(0, 5'h04, 0); chk(rd, 32'hfe);
      repeat (1200) @(posedge sys_clk);
      chk(span, 384);
      report_and_stop;
   end
endmodule
